// ==== hdl/rtclp_consts.svh ====
// Offsets, field positions, reset values and timing counts of the RTC core
// Functional notes
// - While run bit set, the 32-bit timer counts up once per oscillator cycle.
// - Alarm fires only when timer exactly equals the 32-bit compare value.
// - With auto reset, timer clears on the same oscillator cycle on which alarm drops.
// - Writing 1 at the alarm flag position enables auto reset.
// - Load: software fills holding bytes, sets load bit; hardware copies, clears it.
// - Snapshot: software sets bit; hardware copies timer to holding bytes, clears it.
// - Load and snapshot work while the timer keeps running.
// - Writing alarm enable as 0 clears the alarm flag.
// - Alarm flag stays high at most one oscillator cycle.
// - Without auto reset, an unchanged compare repeats after 2^32 cycles.
// - Timer wraps from maximum to zero and keeps counting.
// - Alarm event is offered as an output for interrupt, wake or reset.
// - With detector on, oscillator stuck over 100 us sets failure flag.
// - Missing-clock timeout is offered as an output for interrupt, wake, reset.
// - Crystal-valid status is blanked for 2 ms after oscillator turn-on.
// - Bias-doubling bit set to 1 selects doubled oscillator bias.
// - With gain control on, high amplitude reduces the drive current.
// - Internal registers reached through an address port and a data port.
`ifndef RTCLP_CONSTS_SVH
`define RTCLP_CONSTS_SVH

`define RTCLP_OFF_ADDR 12'h000
`define RTCLP_OFF_DATA 12'h004

`define RTCLP_IDX_CAP0 8'h00
`define RTCLP_IDX_CAP1 8'h01
`define RTCLP_IDX_CAP2 8'h02
`define RTCLP_IDX_CAP3 8'h03
`define RTCLP_IDX_CTL 8'h04
`define RTCLP_IDX_OSC 8'h05
`define RTCLP_IDX_LCAP 8'h06
`define RTCLP_IDX_ALM0 8'h08
`define RTCLP_IDX_HOLD4 8'h0C
`define RTCLP_IDX_HOLD5 8'h0D

`define RTCLP_CTL_EN 7
`define RTCLP_CTL_MCLK 6
`define RTCLP_CTL_FAIL 5
`define RTCLP_CTL_RUN 4
`define RTCLP_CTL_AEN 3
`define RTCLP_CTL_ALARM_EVENT_FLAG 2
`define RTCLP_CTL_SET 1
`define RTCLP_CTL_CAP 0
`define RTCLP_OSC_AGC 6
`define RTCLP_OSC_BIAS 5
`define RTCLP_OSC_VLD 4

`define RTCLP_RST_BYTE 8'h00
`define RTCLP_RST_WORD 32'h0000_0000

`define RTCLP_CLK_MHZ 25
`define RTCLP_MISS_US 100
`define RTCLP_MISS_CYC (`RTCLP_MISS_US * `RTCLP_CLK_MHZ)
`define RTCLP_BLANK_MS 2
`define RTCLP_BLANK_CYC (`RTCLP_BLANK_MS * 1000 * `RTCLP_CLK_MHZ)

`endif

// ==== hdl/rtclp_oscmon.sv ====
// Missing-clock one-shot and crystal-valid blanking
`timescale 1ns/100ps
`include "rtclp_consts.svh"
module rtclp_oscmon
  import rtclp_pkg::*;
#(
  parameter int unsigned BLANK_CYC = `RTCLP_BLANK_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic oscEdge,
  input wire logic detEnable,
  input wire logic oscOn,
  input wire logic ampOk,
  output logic failSet,
  output logic clkValid
);
  localparam logic [11:0] MissCyc = 12'(`RTCLP_MISS_CYC);
  localparam logic [15:0] BlankCyc = 16'(BLANK_CYC);
  logic [11:0] miss_reg, miss_next;
  logic [15:0] blank_reg, blank_next;
  logic valid_reg, valid_next;

  assign clkValid = valid_reg;
  // one-shot when stuck for the full window
  assign failSet = detEnable && !oscEdge && (miss_reg == MissCyc - 12'h001);

  always_comb begin
    miss_next = miss_reg;
    blank_next = blank_reg;
    if (oscEdge || !detEnable) begin
      miss_next = 12'h000;
    end else if (miss_reg != MissCyc) begin
      miss_next = miss_reg + 12'h001;
    end
    if (!oscOn) begin
      blank_next = 16'h0000;
    end else if (blank_reg != BlankCyc) begin
      blank_next = blank_reg + 16'h0001;
    end
    valid_next = ampOk && oscOn && (blank_reg == BlankCyc);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      miss_reg <= 12'h000;
      blank_reg <= 16'h0000;
      valid_reg <= 1'b0;
    end else begin
      miss_reg <= miss_next;
      blank_reg <= blank_next;
      valid_reg <= valid_next;
    end
  end
endmodule

// ==== hdl/rtclp_pkg.sv ====
// Types shared by the RTC core modules
package rtclp_pkg;
  typedef logic [7:0] rtclp_byte_t;
  typedef logic [31:0] rtclp_word_t;
  typedef enum logic [1:0] {PORT_NONE, PORT_ADDR, PORT_DATA} rtclp_port_e;
  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_RDWAIT, ST_RDDONE} rtclp_bus_e;
endpackage

// ==== hdl/rtclp_timer.sv ====
// Timer counter, alarm comparator and load/snapshot transfers
`timescale 1ns/100ps
`include "rtclp_consts.svh"
module rtclp_timer
  import rtclp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  rtclp_tmr_if.tmr t
);
  rtclp_word_t timer_reg, timer_next;
  logic [47:0] hold_reg, hold_next;
  logic load_reg, load_next;
  logic cap_reg, cap_next;
  logic flag_reg, flag_next;
  logic match_reg, match_next;
  logic matchNow;

  assign t.hold = hold_reg;
  assign t.loadReq = load_reg;
  assign t.capReq = cap_reg;
  assign t.alarmFlag = flag_reg;

  always_comb begin
    timer_next = timer_reg;
    hold_next = hold_reg;
    load_next = load_reg | t.setLoad;
    cap_next = cap_reg | t.setCap;
    flag_next = flag_reg;
    match_next = match_reg;
    matchNow = t.aen && (timer_reg == t.alarmVal);
    if (t.holdWr) begin
      hold_next[{t.holdIdx, 3'b000} +: 8] = t.holdWdata;
    end
    if (t.clrFlag) begin
      flag_next = 1'b0;
    end
    if (t.oscTick) begin
      flag_next = matchNow && !match_reg;
      match_next = matchNow;
      // whole word copied in one tick
      if (load_reg) begin
        timer_next = hold_reg[31:0];
        load_next = 1'b0;
      // clear on the tick the flag drops, period compare plus two
      end else if (t.autoRst && flag_reg) begin
        timer_next = `RTCLP_RST_WORD;
      end else if (t.run) begin
        timer_next = timer_reg + 32'h0000_0001;
      end
      if (cap_reg) begin
        hold_next[31:0] = timer_reg;
        cap_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      timer_reg <= `RTCLP_RST_WORD;
      hold_reg <= 48'h0000_0000_0000;
      load_reg <= 1'b0;
      cap_reg <= 1'b0;
      flag_reg <= 1'b0;
      match_reg <= 1'b0;
    end else begin
      timer_reg <= timer_next;
      hold_reg <= hold_next;
      load_reg <= load_next;
      cap_reg <= cap_next;
      flag_reg <= flag_next;
      match_reg <= match_next;
    end
  end
endmodule

// ==== hdl/rtclp_tmr_if.sv ====
// Link between register file and timer core
`timescale 1ns/100ps
interface rtclp_tmr_if;
  import rtclp_pkg::*;
  logic oscTick;
  logic run;
  logic aen;
  logic autoRst;
  rtclp_word_t alarmVal;
  logic holdWr;
  logic [2:0] holdIdx;
  rtclp_byte_t holdWdata;
  logic setLoad;
  logic setCap;
  logic clrFlag;
  logic [47:0] hold;
  logic loadReq;
  logic capReq;
  logic alarmFlag;
  modport ctl (output oscTick, run, aen, autoRst, alarmVal, holdWr, holdIdx, holdWdata,
    setLoad, setCap, clrFlag, input hold, loadReq, capReq, alarmFlag);
  modport tmr (input oscTick, run, aen, autoRst, alarmVal, holdWr, holdIdx, holdWdata,
    setLoad, setCap, clrFlag, output hold, loadReq, capReq, alarmFlag);
endinterface

// ==== hdl/rtclp_top.sv ====
// RTC core top: AHB-Lite slave, indirect register file, oscillator controls
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "rtclp_consts.svh"
module rtclp_top
  import rtclp_pkg::*;
#(
  parameter int unsigned BLANK_CYC = `RTCLP_BLANK_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic oscIn,
  input wire logic xtalAmpOk,
  input wire logic ampHigh,
  output logic oscEnable,
  output logic biasDoubleSel,
  output logic agcEnable,
  output logic driveReduce,
  output logic [3:0] loadCapSel,
  output logic alarmEvent,
  output logic oscFailed
);
  rtclp_tmr_if tif();

  // Bus state
  rtclp_bus_e state_reg, state_next;
  rtclp_port_e port_reg, port_next;
  rtclp_word_t hrdata_reg, hrdata_next;
  logic accept;
  logic wrAddr;
  logic wrData;
  rtclp_byte_t rdVal;

  // Register file state
  rtclp_byte_t addr_reg, addr_next;
  logic oscEn_reg, oscEn_next;
  logic mclk_reg, mclk_next;
  logic fail_reg, fail_next;
  logic run_reg, run_next;
  logic aen_reg, aen_next;
  logic autoRst_reg, autoRst_next;
  logic agc_reg, agc_next;
  logic bias_reg, bias_next;
  logic drive_reg, drive_next;
  logic [3:0] lcap_reg, lcap_next;
  rtclp_word_t alarm_reg, alarm_next;
  logic [3:0] slot;
  logic failSet;
  logic clkValid;

  // Oscillator edge state
  logic oscPrev_reg, oscPrev_next;

  // Maps an internal index to a holding byte: {valid, slot}
  function automatic logic [3:0] holdSlot(input rtclp_byte_t idx);
    logic [3:0] r;
    r = 4'h0;
    if (idx[7:2] == 6'h00) begin
      r = {2'b10, idx[1:0]};
    end else if (idx == `RTCLP_IDX_HOLD4) begin
      r = 4'hC;
    end else if (idx == `RTCLP_IDX_HOLD5) begin
      r = 4'hD;
    end
    return r;
  endfunction

  assign hrdata = hrdata_reg;
  assign hreadyout = (state_reg != ST_RDWAIT);
  assign hresp = 1'b0;
  assign slot = holdSlot(addr_reg);

  // address port and data port decode
  assign accept = hsel && htrans[1] && hready;
  assign wrAddr = (state_reg == ST_WRITE) && (port_reg == PORT_ADDR);
  assign wrData = (state_reg == ST_WRITE) && (port_reg == PORT_DATA);

  always_comb begin
    rdVal = 8'h00;
    if (port_reg == PORT_ADDR) begin
      rdVal = addr_reg;
    end else if (port_reg == PORT_DATA) begin
      if (slot[3]) begin
        rdVal = tif.hold[{slot[2:0], 3'b000} +: 8];
      end else if (addr_reg[7:2] == `RTCLP_IDX_ALM0 >> 2) begin
        rdVal = alarm_reg[{addr_reg[1:0], 3'b000} +: 8];
      end else if (addr_reg == `RTCLP_IDX_CTL) begin
        rdVal = {oscEn_reg, mclk_reg, fail_reg, run_reg, aen_reg, tif.alarmFlag,
          tif.loadReq, tif.capReq};
      end else if (addr_reg == `RTCLP_IDX_OSC) begin
        rdVal = 8'h00;
        rdVal[`RTCLP_OSC_AGC] = agc_reg;
        rdVal[`RTCLP_OSC_BIAS] = bias_reg;
        rdVal[`RTCLP_OSC_VLD] = clkValid;
      end else if (addr_reg == `RTCLP_IDX_LCAP) begin
        rdVal = {4'h0, lcap_reg};
      end
    end
  end

  // Bus slave: writes in data phase, reads take one wait state
  always_comb begin
    state_next = state_reg;
    port_next = port_reg;
    hrdata_next = hrdata_reg;
    unique case (state_reg)
      ST_IDLE, ST_WRITE, ST_RDDONE: begin
        state_next = ST_IDLE;
        if (accept) begin
          if (haddr[11:0] == `RTCLP_OFF_ADDR) begin
            port_next = PORT_ADDR;
          end else if (haddr[11:0] == `RTCLP_OFF_DATA) begin
            port_next = PORT_DATA;
          end else begin
            port_next = PORT_NONE;
          end
          state_next = hwrite ? ST_WRITE : ST_RDWAIT;
        end
      end
      ST_RDWAIT: begin
        hrdata_next = {24'h00_0000, rdVal};
        state_next = ST_RDDONE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      port_reg <= PORT_NONE;
      hrdata_reg <= `RTCLP_RST_WORD;
    end else begin
      state_reg <= state_next;
      port_reg <= port_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // Register file writes and control strobes
  always_comb begin
    addr_next = addr_reg;
    oscEn_next = oscEn_reg;
    mclk_next = mclk_reg;
    fail_next = fail_reg;
    run_next = run_reg;
    aen_next = aen_reg;
    autoRst_next = autoRst_reg;
    agc_next = agc_reg;
    bias_next = bias_reg;
    lcap_next = lcap_reg;
    alarm_next = alarm_reg;
    tif.holdWr = 1'b0;
    tif.holdIdx = slot[2:0];
    tif.holdWdata = hwdata[7:0];
    tif.setLoad = 1'b0;
    tif.setCap = 1'b0;
    tif.clrFlag = 1'b0;
    if (wrAddr) begin
      addr_next = hwdata[7:0];
    end
    if (wrData) begin
      if (slot[3]) begin
        tif.holdWr = 1'b1;
      end else if (addr_reg[7:2] == `RTCLP_IDX_ALM0 >> 2) begin
        alarm_next[{addr_reg[1:0], 3'b000} +: 8] = hwdata[7:0];
      end else if (addr_reg == `RTCLP_IDX_CTL) begin
        oscEn_next = hwdata[`RTCLP_CTL_EN];
        mclk_next = hwdata[`RTCLP_CTL_MCLK];
        if (!hwdata[`RTCLP_CTL_FAIL]) begin
          fail_next = 1'b0;
        end
        run_next = hwdata[`RTCLP_CTL_RUN];
        aen_next = hwdata[`RTCLP_CTL_AEN];
        tif.clrFlag = !hwdata[`RTCLP_CTL_AEN];
        autoRst_next = hwdata[`RTCLP_CTL_ALARM_EVENT_FLAG];
        tif.setLoad = hwdata[`RTCLP_CTL_SET];
        tif.setCap = hwdata[`RTCLP_CTL_CAP];
      end else if (addr_reg == `RTCLP_IDX_OSC) begin
        agc_next = hwdata[`RTCLP_OSC_AGC];
        bias_next = hwdata[`RTCLP_OSC_BIAS];
      end else if (addr_reg == `RTCLP_IDX_LCAP) begin
        lcap_next = hwdata[3:0];
      end
    end
    if (failSet) begin
      fail_next = 1'b1;
    end
    // reduce drive once amplitude is high
    drive_next = agc_reg && ampHigh;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      addr_reg <= `RTCLP_RST_BYTE;
      oscEn_reg <= 1'b0;
      mclk_reg <= 1'b0;
      fail_reg <= 1'b0;
      run_reg <= 1'b0;
      aen_reg <= 1'b0;
      autoRst_reg <= 1'b0;
      agc_reg <= 1'b0;
      bias_reg <= 1'b0;
      drive_reg <= 1'b0;
      lcap_reg <= 4'h0;
      alarm_reg <= `RTCLP_RST_WORD;
    end else begin
      addr_reg <= addr_next;
      oscEn_reg <= oscEn_next;
      mclk_reg <= mclk_next;
      fail_reg <= fail_next;
      run_reg <= run_next;
      aen_reg <= aen_next;
      autoRst_reg <= autoRst_next;
      agc_reg <= agc_next;
      bias_reg <= bias_next;
      drive_reg <= drive_next;
      lcap_reg <= lcap_next;
      alarm_reg <= alarm_next;
    end
  end

  // Oscillator input edge tracking
  always_comb begin
    oscPrev_next = oscIn;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      oscPrev_reg <= 1'b0;
    end else begin
      oscPrev_reg <= oscPrev_next;
    end
  end

  // one tick per oscillator rising edge
  assign tif.oscTick = oscIn && !oscPrev_reg;
  assign tif.run = run_reg;
  assign tif.aen = aen_reg;
  assign tif.autoRst = autoRst_reg;
  assign tif.alarmVal = alarm_reg;

  rtclp_timer u_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .t(tif.tmr)
  );

  rtclp_oscmon #(
    .BLANK_CYC(BLANK_CYC)
  ) u_oscmon (
    .clk_sys(clk_sys),
    .reset(reset),
    .oscEdge(oscIn ^ oscPrev_reg),
    .detEnable(mclk_reg),
    .oscOn(oscEn_reg),
    .ampOk(xtalAmpOk),
    .failSet(failSet),
    .clkValid(clkValid)
  );

  assign oscEnable = oscEn_reg;
  assign biasDoubleSel = bias_reg;
  assign agcEnable = agc_reg;
  assign driveReduce = drive_reg;
  assign loadCapSel = lcap_reg;
  assign alarmEvent = tif.alarmFlag;
  assign oscFailed = fail_reg;
endmodule

// ==== tb/rtclp_top_assertions.sv ====
// Bus, alarm, fail-flag and control-output checks for the RTC core top
`timescale 1ns/100ps
`include "rtclp_consts.svh"
module rtclp_top_chk
  import rtclp_pkg::*;
#(
  parameter int unsigned BLANK_CYC = `RTCLP_BLANK_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic oscIn,
  input wire logic xtalAmpOk,
  input wire logic ampHigh,
  input wire logic oscEnable,
  input wire logic biasDoubleSel,
  input wire logic agcEnable,
  input wire logic driveReduce,
  input wire logic [3:0] loadCapSel,
  input wire logic alarmEvent,
  input wire logic oscFailed
);
  localparam int QUIET_MIN = 2490;
  logic oscPrev_reg, oscPrev_next, wrPhase_reg, wrPhase_next, tickNow;
  logic [11:0] quiet_reg, quiet_next;
  // Oscillator edge, write data phase and quiet-time tracking
  always_comb begin
    tickNow = oscIn & ~oscPrev_reg;
    oscPrev_next = oscIn;
    wrPhase_next = hsel & htrans[1] & hready & hwrite;
    quiet_next = (oscIn != oscPrev_reg) ? 12'h000 : quiet_reg + {11'h000, ~&quiet_reg};
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      oscPrev_reg <= 1'b0;
      wrPhase_reg <= 1'b0;
      quiet_reg <= 12'h000;
    end else begin
      oscPrev_reg <= oscPrev_next;
      wrPhase_reg <= wrPhase_next;
      quiet_reg <= quiet_next;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  sequence rdReq_s;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence rdWait_s;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_read_wait: assert property (rdReq_s |=> rdWait_s)
    else $error("read data phase without one wait state");
  chk_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  chk_read_upper: assert property (rdReq_s ##2 hreadyout |-> hrdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not OKAY");
  chk_alarm_drop: assert property (alarmEvent && tickNow |=> !alarmEvent)
    else $error("alarm flag held past one tick");
  chk_alarm_on_tick: assert property ($rose(alarmEvent) |-> $past(tickNow))
    else $error("alarm flag rose without a tick");
  chk_fail_quiet: assert property ($rose(oscFailed) |-> quiet_reg >= QUIET_MIN)
    else $error("failure flag set too early");
  chk_fail_sticky: assert property ($fell(oscFailed) |-> $past(wrPhase_reg))
    else $error("failure flag cleared without a write");
  chk_cfg_write: assert property ($changed({oscEnable, biasDoubleSel, agcEnable, loadCapSel})
    |-> $past(wrPhase_reg))
    else $error("control output changed without a write");
  chk_drive_on: assert property (agcEnable && ampHigh |=> driveReduce)
    else $error("drive not reduced at high amplitude");
  chk_drive_off: assert property (!agcEnable |=> !driveReduce)
    else $error("drive reduced with gain control off");
endmodule
bind rtclp_top rtclp_top_chk #(.BLANK_CYC(BLANK_CYC)) chk (.*);

// ==== tb/tb_low_power_rtc_timer_alarm.sv ====
// Self-checking bench for the RTC core top over AHB-Lite
`timescale 1ns/100ps
`include "rtclp_consts.svh"
module tb_low_power_rtc_timer_alarm;
  import rtclp_pkg::*;
  localparam int unsigned BLANK = 20;
  localparam logic [31:0] PA = {20'h0_0000, `RTCLP_OFF_ADDR};
  localparam logic [31:0] PD = {20'h0_0000, `RTCLP_OFF_DATA};
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic oscIn = 1'b0;
  logic xtalAmpOk = 1'b0;
  logic ampHigh = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, oscEnable, biasDoubleSel, agcEnable, driveReduce;
  logic alarmEvent, oscFailed;
  logic [3:0] loadCapSel;
  int errTotal = 0;
  int checked = 0;
  int hits, first, gap, n;
  rtclp_byte_t rd;
  rtclp_word_t word, junk;

  always #20 clk_sys = ~clk_sys;

  rtclp_top #(.BLANK_CYC(BLANK)) DUT (.*, .hready(hreadyout));

  task automatic giveVerdict;
    $display("Comparisons %0d, mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic compare(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Waits for hready high at a falling edge, taking read data there, then steps to the next rising edge
  task automatic waitReady(output rtclp_word_t data);
    int k;
    k = 0;
    @(negedge clk_sys);
    while (hreadyout !== 1'b1 && k < 50) begin
      k++;
      @(negedge clk_sys);
    end
    if (k >= 50) begin
      errTotal++;
      $display("ERROR bus ready expected 1 seen stuck low");
      giveVerdict;
    end else begin
      data = hrdata;
      @(posedge clk_sys);
    end
  endtask
  task automatic busWr(input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= 1'b1;
    waitReady(junk);
    htrans <= 2'b00;
    hwdata <= d;
    waitReady(junk);
  endtask
  task automatic busRd(input logic [31:0] a, output rtclp_word_t d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= 1'b0;
    waitReady(junk);
    htrans <= 2'b00;
    waitReady(d);
  endtask
  task automatic wreg(input logic [7:0] idx, input rtclp_byte_t v);
    busWr(PA, {24'h00_0000, idx});
    busWr(PD, {24'h00_0000, v});
  endtask
  task automatic rreg(input logic [7:0] idx, output rtclp_byte_t v);
    rtclp_word_t w;
    busWr(PA, {24'h00_0000, idx});
    busRd(PD, w);
    v = w[7:0];
  endtask
  task automatic wword(input logic [7:0] base, input rtclp_word_t w);
    for (int i = 0; i < 4; i++) wreg(base + 8'(i), w[8*i +: 8]);
  endtask
  task automatic tick;
    oscIn <= 1'b1;
    @(posedge clk_sys);
    oscIn <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic snap(output rtclp_word_t w);
    wreg(`RTCLP_IDX_CTL, 8'h91);
    tick;
    rreg(`RTCLP_IDX_CTL, rd);
    compare("snapshot bit", 32'(rd), 32'h0000_0090);
    for (int i = 0; i < 4; i++) begin
      rreg(`RTCLP_IDX_CAP0 + 8'(i), rd);
      w[8*i +: 8] = rd;
    end
  endtask
  task automatic tickCount(input int cnt);
    hits = 0;
    gap = 0;
    for (int i = 0; i < cnt; i++) begin
      tick;
      if (alarmEvent === 1'b1) begin
        if (hits == 1) gap = i - first;
        if (hits == 0) first = i;
        hits++;
      end
    end
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rreg(`RTCLP_IDX_CTL, rd);
    compare("control reset", 32'(rd), 32'h0000_0000);
    rreg(`RTCLP_IDX_OSC, rd);
    compare("osc reset", 32'(rd), 32'h0000_0000);
    busRd(32'h0000_0010, word);
    compare("unmapped read", word, 32'h0000_0000);
    $display("test reset done");
    ampHigh <= 1'b1;
    wreg(`RTCLP_IDX_OSC, 8'h60);
    wreg(`RTCLP_IDX_LCAP, 8'h0E);
    @(negedge clk_sys);
    compare("bias double", 32'(biasDoubleSel), 32'h0000_0001);
    compare("gain control", 32'(agcEnable), 32'h0000_0001);
    compare("drive reduce", 32'(driveReduce), 32'h0000_0001);
    compare("load cap", 32'(loadCapSel), 32'h0000_000E);
    @(posedge clk_sys);
    wreg(`RTCLP_IDX_OSC, 8'h00);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    compare("drive relaxed", 32'(driveReduce), 32'h0000_0000);
    @(posedge clk_sys);
    $display("test osc controls done");
    xtalAmpOk <= 1'b1;
    wreg(`RTCLP_IDX_CTL, 8'h80);
    rreg(`RTCLP_IDX_OSC, rd);
    compare("valid blanked", 32'(rd), 32'h0000_0000);
    repeat (BLANK + 5) @(posedge clk_sys);
    rreg(`RTCLP_IDX_OSC, rd);
    compare("valid shown", 32'(rd), 32'h0000_0010);
    compare("osc enable", 32'(oscEnable), 32'h0000_0001);
    $display("test crystal valid done");
    wword(`RTCLP_IDX_CAP0, 32'hFFFF_FFFF);
    wreg(`RTCLP_IDX_CTL, 8'h92);
    tick;
    rreg(`RTCLP_IDX_CTL, rd);
    compare("load bit", 32'(rd), 32'h0000_0090);
    snap(word);
    compare("snapshot max", word, 32'hFFFF_FFFF);
    snap(word);
    compare("snapshot wrap", word, 32'h0000_0000);
    repeat (3) tick;
    snap(word);
    compare("count up", word, 32'h0000_0004);
    wreg(`RTCLP_IDX_HOLD4, 8'hA5);
    wreg(`RTCLP_IDX_HOLD5, 8'h5A);
    rreg(`RTCLP_IDX_HOLD4, rd);
    compare("holding byte 4", 32'(rd), 32'h0000_00A5);
    rreg(`RTCLP_IDX_HOLD5, rd);
    compare("holding byte 5", 32'(rd), 32'h0000_005A);
    $display("test load snapshot done");
    wword(`RTCLP_IDX_CAP0, 32'h0000_0010);
    wword(`RTCLP_IDX_ALM0, 32'h0000_000F);
    wreg(`RTCLP_IDX_CTL, 8'h9A);
    tickCount(6);
    compare("no match below", 32'(hits), 32'h0000_0000);
    wreg(`RTCLP_IDX_CTL, 8'h90);
    wword(`RTCLP_IDX_ALM0, 32'h0000_0018);
    wreg(`RTCLP_IDX_CTL, 8'h98);
    n = 0;
    while (alarmEvent !== 1'b1 && n < 8) begin
      tick;
      n++;
    end
    compare("alarm match", 32'(alarmEvent), 32'h0000_0001);
    wreg(`RTCLP_IDX_CTL, 8'h90);
    @(negedge clk_sys);
    compare("alarm cleared", 32'(alarmEvent), 32'h0000_0000);
    @(posedge clk_sys);
    $display("test alarm done");
    wword(`RTCLP_IDX_CAP0, 32'h0000_0000);
    wword(`RTCLP_IDX_ALM0, 32'h0000_0003);
    wreg(`RTCLP_IDX_CTL, 8'h9E);
    rreg(`RTCLP_IDX_CTL, rd);
    compare("auto reset not flag", 32'(rd), 32'h0000_009A);
    tickCount(20);
    compare("auto reset period", 32'(gap), 32'h0000_0005);
    wreg(`RTCLP_IDX_CTL, 8'h90);
    $display("test auto reset done");
    wreg(`RTCLP_IDX_CTL, 8'hC0);
    repeat (2400) @(posedge clk_sys);
    @(negedge clk_sys);
    compare("fail early", 32'(oscFailed), 32'h0000_0000);
    repeat (200) @(posedge clk_sys);
    @(negedge clk_sys);
    compare("fail set", 32'(oscFailed), 32'h0000_0001);
    @(posedge clk_sys);
    wreg(`RTCLP_IDX_CTL, 8'h80);
    wreg(`RTCLP_IDX_CTL, 8'h80);
    @(negedge clk_sys);
    compare("fail cleared", 32'(oscFailed), 32'h0000_0000);
    $display("test missing clock done");
    giveVerdict;
  end
endmodule
